// ---- inc/dtc_params.svh ----
// constants for the diagnostic trend capture block
// assumes a 250 MHz core clock; included by the package and the design
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_W          16       // width of one traced parameter
`define DTC_NCH        8        // number of trace channels
`define DTC_RATE_MAX   20000    // longest sample interval, ms
`define DTC_PCT_MAX    100      // post-trigger share, percent
`define DTC_DEPTH_S    100      // short buffer, samples per trace
`define DTC_DEPTH_L    1000     // long buffer, samples per trace
`define DTC_MS_NS      1000000  // one millisecond in ns
`define DTC_CLK_NS     4        // core clock period in ns
`define DTC_FIFO_DEPTH 16       // words in the sample fifo
`endif

// ---- inc/dtc_pkg.sv ----
// types shared by the trend capture design
// assumes dtc_params.svh sits beside it on the include path
`include "dtc_params.svh"
package dtc_pkg;
   typedef logic [`DTC_W-1:0] dtc_word_t;           // one parameter value
   typedef struct packed {
      dtc_word_t [`DTC_NCH-1:0] ch;                 // channel 0 is the trigger trace
   } dtc_sample_t;
   typedef enum logic [1:0] {
      DTC_ARM  = 2'b00,                             // armed, circular pre-trigger fill
      DTC_POST = 2'b01,                             // triggered, taking post samples
      DTC_DONE = 2'b10                              // frozen, capture complete
   } dtc_state_t;
   typedef enum logic [2:0] {
      DTC_GT  = 3'b000,                             // value above trigger level
      DTC_LT  = 3'b001,                             // value below trigger level
      DTC_EQ  = 3'b010,                             // value equal
      DTC_NE  = 3'b011,                             // value differs
      DTC_OR  = 3'b100,                             // "+": any masked bit set
      DTC_AND = 3'b101                              // all masked bits set
   } dtc_cond_t;
   typedef struct packed {
      logic [14:0]        rate_ms;                  // interval between samples, ms
      logic [6:0]         post_pct;                 // post-trigger share, percent
      logic [`DTC_NCH-1:0] chan_en;                 // active traces
      logic               cont;                     // 1 = continuous (C), 0 = single (S)
      dtc_cond_t          cond;                     // trigger comparison
      dtc_word_t          value;                    // trigger value
      logic               deep;                     // 1 = 1000 samples, 0 = 100
   } dtc_cfg_t;
endpackage

// ---- logic/dtc_trend.sv ----
// diagnostic trend recorder with its sample fifo
// assumes params, config and commands come from logic on core_clk
// What this block does
// - sample interval programmable, 0 to 20000 ms
// - zero interval samples at fastest rate
// - post-trigger share programmable, 0 to 100%
// - eight traces, each may be inactive
// - only trace one can fire trigger
// - mode flag selects single or continuous
// - single mode triggers once, waits re-arm
// - continuous re-arms until a view stops
// - trigger value compared against trace one
// - condition selects comparison, OR included
// - rest of buffer holds pre-trigger samples
// - read-out returns current buffer; last capture only while frozen
// - depth is 100 or 1000 samples
// - re-arm clears data, enables next trigger
`timescale 1ns/1ps
`include "dtc_params.svh"

// plain valid/ready fifo, count based so full and empty are exact
module dtc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];              // storage
   logic [AW-1:0] rd_ptr;                   // next word out
   logic [AW-1:0] wr_ptr;                   // next free slot
   logic [AW:0]   count;                    // words held
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   // storage needs no reset; only pointers and count carry state
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module dtc_trend
   import dtc_pkg::*;
#(
   parameter int CYC_PER_MS = `DTC_MS_NS / `DTC_CLK_NS,   // cycles per millisecond
   parameter int DEPTH_S    = `DTC_DEPTH_S,
   parameter int DEPTH_L    = `DTC_DEPTH_L,
   parameter int FIFO_DEPTH = `DTC_FIFO_DEPTH
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire dtc_cfg_t    cfg,           // configuration, held steady by software
   input  wire dtc_sample_t param_in,      // live read-only parameters
   input  wire logic        rearm,         // pulse: clear buffer, arm trigger
   input  wire logic        rd_req,        // pulse: read one stored sample
   input  wire logic [9:0]  rd_idx,        // 0 = oldest stored sample
   output dtc_sample_t      rd_data,       // registered read data
   output logic             rd_valid,      // pulse one cycle after rd_req
   output dtc_state_t       state,         // capture state
   output logic             complete,      // capture frozen
   output logic [9:0]       stored,        // samples held in buffer
   output logic             stopped        // continuous capture stopped by a view
);
   localparam int SW = $bits(dtc_sample_t);

   dtc_sample_t mem [DEPTH_L];             // capture buffer, one word per sample
   logic [17:0] ms_cnt;                    // millisecond prescaler
   logic [14:0] intv_cnt;                  // elapsed ms in interval
   logic        tick_pend;                 // a sample is due but not yet taken
   logic [9:0]  wr_ptr;                    // next circular slot
   logic [9:0]  oldest;                    // slot of oldest sample once frozen
   logic [9:0]  post_cnt;                  // post samples taken so far
   dtc_state_t  next_state;

   // interval: clamp so an out-of-range entry cannot stretch past the limit
   wire [14:0] rate_eff   = (cfg.rate_ms > 15'(`DTC_RATE_MAX)) ? 15'(`DTC_RATE_MAX) : cfg.rate_ms;
   wire        ms_tick    = (ms_cnt == 18'(CYC_PER_MS - 1));
   wire        capturing  = (state != DTC_DONE);
   wire        interval_up = ms_tick && (intv_cnt >= rate_eff - 15'd1);
   wire        sample_due = capturing && ((rate_eff == 15'd0) || interval_up);

   // buffer depth and how it splits into pre and post parts
   wire [9:0]  depth      = cfg.deep ? 10'(DEPTH_L) : 10'(DEPTH_S);
   wire [6:0]  pct        = (cfg.post_pct > 7'(`DTC_PCT_MAX)) ? 7'(`DTC_PCT_MAX) : cfg.post_pct;
   wire [16:0] post_prod  = 17'(depth) * 17'(pct);
   wire [9:0]  post_need  = 10'(post_prod / 17'(`DTC_PCT_MAX));
   wire [9:0]  pre_need   = depth - post_need;

   // sample path: due sample -> fifo -> buffer; read-out steals the write port
   dtc_sample_t push_data;
   dtc_sample_t pop_data;
   logic        push_ready;
   logic        pop_valid;
   wire         pop_ready  = capturing && !rd_req;
   wire         push       = tick_pend && push_ready;
   wire         wr_en      = pop_valid && pop_ready;
   // samples still queued from a finished capture must not leak into the next one
   wire         flush      = rearm || (state == DTC_DONE && next_state == DTC_ARM);
   // a view in continuous mode; it wins over a re-arm in the same cycle
   wire         view_stop  = rd_req && cfg.cont;

   // inactive traces record as zero
   genvar gi;
   generate
      for (gi = 0; gi < `DTC_NCH; gi++) begin : g_ch
         assign push_data.ch[gi] = cfg.chan_en[gi] ? param_in.ch[gi] : '0;
      end
   endgenerate

   dtc_fifo #(
      .W     (SW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst || flush),
      .in_valid  (tick_pend),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_data)
   );

   // trigger looks at trace one only
   wire dtc_word_t t0 = pop_data.ch[0];
   logic           cond_hit;
   always_comb begin
      unique case (cfg.cond)
         DTC_GT:  cond_hit = (t0 > cfg.value);
         DTC_LT:  cond_hit = (t0 < cfg.value);
         DTC_EQ:  cond_hit = (t0 == cfg.value);
         DTC_NE:  cond_hit = (t0 != cfg.value);
         DTC_OR:  cond_hit = ((t0 & cfg.value) != '0);
         DTC_AND: cond_hit = ((t0 & cfg.value) == cfg.value);
         default: cond_hit = 1'b0;          // unused codes never fire
      endcase
   end

   // trigger is held off until the pre part is full, so that share is honoured
   wire [9:0] stored_inc = (stored == depth) ? stored : stored + 10'd1;
   wire       trig_fire  = wr_en && (state == DTC_ARM) && cond_hit && (stored_inc >= pre_need);
   wire       post_last  = wr_en && (state == DTC_POST) && (post_cnt == post_need - 10'd1);
   wire [9:0] wr_ptr_inc = (wr_ptr == depth - 10'd1) ? 10'd0 : wr_ptr + 10'd1;

   // next state
   always_comb begin
      next_state = state;
      unique case (state)
         DTC_ARM: begin
            if (trig_fire) begin
               next_state = (post_need == 10'd0) ? DTC_DONE : DTC_POST;
            end
         end
         DTC_POST: begin
            if (post_last) begin
               next_state = DTC_DONE;
            end
         end
         DTC_DONE: begin
            // single mode stays frozen here until a re-arm
            if (cfg.cont && !stopped) begin
               next_state = DTC_ARM;
            end
         end
         default: next_state = DTC_ARM;
      endcase
      if (rearm) begin
         next_state = DTC_ARM;
      end
   end

   // sample timing; the prescaler free-runs so intervals stay aligned
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ms_cnt    <= '0;
         intv_cnt  <= '0;
         tick_pend <= 1'b0;
      end else begin
         ms_cnt <= ms_tick ? '0 : ms_cnt + 18'd1;
         if (interval_up || rate_eff == 15'd0) begin
            intv_cnt <= '0;
         end else if (ms_tick) begin
            intv_cnt <= intv_cnt + 15'd1;
         end
         // a full fifo holds the due sample back rather than dropping it
         tick_pend <= sample_due || (tick_pend && !push_ready && capturing);
      end
   end

   // capture state, pointers and counts
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state    <= DTC_ARM;
         wr_ptr   <= '0;
         oldest   <= '0;
         post_cnt <= '0;
         stored   <= '0;
         stopped  <= 1'b0;
      end else begin
         state <= next_state;
         if (rearm || (state == DTC_DONE && next_state == DTC_ARM)) begin
            wr_ptr   <= '0;
            post_cnt <= '0;
            stored   <= '0;
         end else if (wr_en) begin
            wr_ptr   <= wr_ptr_inc;
            stored   <= stored_inc;
            post_cnt <= (state == DTC_POST) ? post_cnt + 10'd1 : post_cnt;
            oldest   <= (stored_inc == depth) ? wr_ptr_inc : 10'd0;
         end
         // a view stops continuous capture; only re-arm resumes it, and the view wins a tie
         if (view_stop) begin
            stopped <= 1'b1;
         end else if (rearm) begin
            stopped <= 1'b0;
         end
      end
   end

   // buffer write; mode flag decides what happens at freeze
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_ptr] <= pop_data;
      end
   end

   // read-out, oldest first, zero beyond what is stored
   wire [10:0] rd_sum  = 11'(oldest) + 11'(rd_idx);
   wire [9:0]  rd_addr = (rd_sum >= 11'(depth)) ? 10'(rd_sum - 11'(depth)) : rd_sum[9:0];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            rd_data <= (rd_idx < stored) ? mem[rd_addr] : '0;
         end
      end
   end

   assign complete = (state == DTC_DONE);

   // checks
   property p_rate_clamp;
      @(posedge core_clk) disable iff (rst) rate_eff <= 15'd20000;
   endproperty
   a_rate_clamp: assert property (p_rate_clamp) else $error("interval exceeds limit");

   property p_fast;
      @(posedge core_clk) disable iff (rst) (cfg.rate_ms == 15'd0 && capturing && !rearm) |=> tick_pend;
   endproperty
   a_fast: assert property (p_fast) else $error("zero interval did not sample");

   property p_post_range;
      @(posedge core_clk) disable iff (rst) (post_need <= depth) && (pre_need + post_need == depth);
   endproperty
   a_post_range: assert property (p_post_range) else $error("post share out of range");

   property p_inactive;
      @(posedge core_clk) disable iff (rst) !cfg.chan_en[7] |-> push_data.ch[7] == '0;
   endproperty
   a_inactive: assert property (p_inactive) else $error("inactive trace recorded");

   property p_no_hit_no_trig;
      @(posedge core_clk) disable iff (rst) (state == DTC_ARM && !cond_hit && !rearm) |=> state == DTC_ARM;
   endproperty
   a_no_hit_no_trig: assert property (p_no_hit_no_trig) else $error("trigger without condition");

   property p_single_hold;
      @(posedge core_clk) disable iff (rst) (state == DTC_DONE && !cfg.cont && !rearm) |=> state == DTC_DONE;
   endproperty
   a_single_hold: assert property (p_single_hold) else $error("single shot left done");

   property p_cont_rearm;
      @(posedge core_clk) disable iff (rst)
         (state == DTC_DONE && cfg.cont && !stopped && !rearm) |=> (state == DTC_ARM && stored == 10'd0);
   endproperty
   a_cont_rearm: assert property (p_cont_rearm) else $error("continuous did not re-arm");

   property p_rearm_clear;
      @(posedge core_clk) disable iff (rst)
         rearm |=> (state == DTC_ARM && stored == 10'd0 && stopped == $past(view_stop));
   endproperty
   a_rearm_clear: assert property (p_rearm_clear) else $error("re-arm did not clear");

   property p_post_freeze;
      @(posedge core_clk) disable iff (rst) (post_last && !rearm) |=> (complete && post_cnt == post_need);
   endproperty
   a_post_freeze: assert property (p_post_freeze) else $error("post count wrong at freeze");

   property p_read;
      @(posedge core_clk) disable iff (rst) (rd_req && rd_idx >= stored) |=> (rd_valid && rd_data == '0);
   endproperty
   a_read: assert property (p_read) else $error("empty slot read nonzero");
endmodule

// ---- tb/test_diagnostic_trend_capture.sv ----
// self-checking bench for the trend recorder, driving its ports directly
// assumes dtc_pkg and dtc_trend are compiled first; one 250 MHz clock
`timescale 1ns/1ps
module test_diagnostic_trend_capture;
   import dtc_pkg::*;
   localparam int CPM = 4;                     // short millisecond keeps rate runs brief
   logic        core_clk  = 1'b0;              // core clock
   logic        rst       = 1'b1;              // sync reset, high
   logic        rearm     = 1'b0;              // re-arm pulse
   logic        rd_req    = 1'b0;              // read pulse
   logic [9:0]  rd_idx    = 10'h000;           // read index
   dtc_cfg_t    cfg       = '0;                // configuration
   dtc_sample_t param_in;                      // live parameters
   dtc_sample_t rd_data;                       // read data
   logic        rd_valid;                      // read strobe
   dtc_state_t  state;                         // capture state
   logic        complete;                      // capture frozen
   logic [9:0]  stored;                        // fill count
   logic        stopped;                       // continuous stopped by a view
   logic [15:0] stamp     = 16'h0000;          // free-running time stamp
   logic [31:0] rng       = 32'd48466;         // xorshift state, fixed seed
   int          err_count = 0;                 // mismatches
   int          tests_run = 0;                 // comparisons
   dtc_sample_t d;                             // scratch read result

   dtc_trend #(.CYC_PER_MS(CPM)) uut (.core_clk(core_clk), .rst(rst), .cfg(cfg), .param_in(param_in),
      .rearm(rearm), .rd_req(rd_req), .rd_idx(rd_idx), .rd_data(rd_data), .rd_valid(rd_valid),
      .state(state), .complete(complete), .stored(stored), .stopped(stopped));

   // clock, half period of 2 ns
   always #2 core_clk = ~core_clk;
   // stamp moves every cycle so each stored word tells when it was taken
   always @(posedge core_clk) stamp <= stamp + 16'h0001;
   // every trace carries the stamp plus its own offset, so traces can be told apart
   always_comb begin
      for (int k = 0; k < 8; k++) param_in.ch[k] = stamp + 16'h1111 * 16'(k);
   end

   // repeatable pseudo-random numbers
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // expected outcome of the trigger comparison; unused codes never fire
   function automatic logic cond_hit(input dtc_cond_t c, input dtc_word_t t, input dtc_word_t v);
      case (c)
         DTC_GT:  return t > v;
         DTC_LT:  return t < v;
         DTC_EQ:  return t == v;
         DTC_NE:  return t != v;
         DTC_OR:  return (t & v) != 16'h0000;
         DTC_AND: return (t & v) == v;
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one read: request for one cycle, answer expected exactly one cycle later
   task automatic rd(input logic [9:0] i, output dtc_sample_t q);
      @(posedge core_clk);
      rd_req <= 1'b1;
      rd_idx <= i;
      @(posedge core_clk);
      rd_req <= 1'b0;
      #1;
      chk(rd_valid, 1'b1, "read strobe missing");
      q = rd_data;
   endtask

   // bounded wait for the frozen state; running out ends the run
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (complete !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      if (complete !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t capture never completed", $time);
         complete_run();
      end
   endtask

   // load a configuration together with a re-arm pulse
   task automatic start(input int c, input dtc_word_t v, input int pct, input int rate,
                        input logic deep, input logic cont, input logic [7:0] en);
      @(posedge core_clk);
      cfg <= '{rate_ms: 15'(rate), post_pct: 7'(pct), chan_en: en, cont: cont,
               cond: dtc_cond_t'(3'(c)), value: v, deep: deep};
      rearm <= 1'b1;
      @(posedge core_clk);
      rearm <= 1'b0;
      #1;
      chk({state, stored, stopped}, {DTC_ARM, 10'h000, 1'b0}, "re-arm did not clear");
   endtask

   // full single-shot capture, then read back and check every stored word
   task automatic cap(input dtc_cond_t c, input dtc_word_t v, input int pct, input int rate, input logic deep);
      int         depth;
      int         step;
      int         trig;
      logic [7:0] en;
      dtc_word_t  first;
      depth = deep ? 1000 : 100;
      step  = (rate == 0) ? 1 : rate * CPM;
      // trigger word sits just before the floor(depth*pct/100) post samples
      trig  = depth - 1 - (depth * pct) / 100;
      en    = 8'(xs()) | 8'h01;
      start(c, v, pct, rate, deep, 1'b0, en);
      wait_done((depth + 200) * step + 200);
      chk({state, stored}, {DTC_DONE, 10'(depth)}, "frozen capture wrong");
      for (int i = 0; i < depth; i++) begin
         rd(10'(i), d);
         if (i == 0) first = d.ch[0];
         chk(d.ch[0], first + 16'(i * step), "sample spacing");
         for (int k = 1; k < 8; k++)
            chk(d.ch[k], en[k] ? d.ch[0] + 16'h1111 * 16'(k) : 16'h0000, "trace content");
         if (i == trig) chk(cond_hit(c, d.ch[0], v), 1'b1, "trigger sample");
         if (i == trig - 1 && (c == DTC_GT || c == DTC_EQ) && rate == 0)
            chk(cond_hit(c, d.ch[0], v), 1'b0, "sample before trigger");
      end
      rd(10'h3ff, d);
      chk(d, '0, "read past fill");
      tick(40);
      chk({state, stored}, {DTC_DONE, 10'(depth)}, "single shot left frozen state");
   endtask

   // main sequence
   initial begin
      int         pcts[6];
      dtc_word_t  v;
      pcts = '{0, 20, 50, 99, 5, 75};
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk({state, stored, complete, rd_valid, stopped}, {DTC_ARM, 10'h000, 3'b000}, "reset state");
      // each of the six defined condition codes 0 to 5 at zero interval, varied post share
      for (int c = 0; c < 6; c++) begin
         case (c)
            3: v = stamp;
            4: v = 16'h0004;
            5: v = 16'h0003;
            default: v = stamp + 16'd150;
         endcase
         cap(dtc_cond_t'(3'(c)), v, pcts[c], 0, 1'b0);
      end
      // random interval and post share
      cap(DTC_NE, stamp, int'(xs() % 100), 1 + int'(xs() % 3), 1'b0);
      // long buffer
      cap(DTC_NE, stamp, 10, 0, 1'b1);
      // unused condition codes 6 and 7 never fire; buffer fills and stays armed
      for (int c = 6; c < 8; c++) begin
         start(c, 16'h0000, 20, 0, 1'b0, 1'b0, 8'hff);
         tick(300);
         chk({state, stored}, {DTC_ARM, 10'd100}, "unused code fired");
      end
      // continuous: automatic re-arm, then a view stops it
      start(int'(DTC_NE), stamp, 20, 0, 1'b0, 1'b1, 8'hff);
      wait_done(600);
      tick(1);
      chk({state, stored}, {DTC_ARM, 10'h000}, "no automatic re-arm");
      rd(10'h000, d);
      chk(stopped, 1'b1, "view did not stop");
      wait_done(600);
      tick(30);
      chk(state, DTC_DONE, "stopped capture re-armed");
      start(int'(DTC_NE), stamp, 20, 0, 1'b0, 1'b0, 8'hff);
      complete_run();
   end
endmodule
